// ---- inc/ple_consts.vh ----
// Constants for the programmable logic element: register map, fields, modes, reset values
`ifndef PLE_CONSTS_VH
`define PLE_CONSTS_VH

// ===================================
// Register map
`define PLE_ADDR_W 8
`define PLE_OFF_CTRL 8'h00
`define PLE_OFF_LUT 8'h04
`define PLE_OFF_STATUS 8'h08

// ===================================
// Control register fields
`define PLE_CTRL_W 12
`define PLE_CTRL_RST 12'h000
`define PLE_F_MODE_HI 1
`define PLE_F_MODE_LO 0
`define PLE_F_LUT_CARRY 2
`define PLE_F_CASC_EN 3
`define PLE_F_PACKED 4
`define PLE_F_LOCAL_REG 5
`define PLE_F_GLOBAL_REG 6
`define PLE_F_CE_FIRST_DATA_INPUT 7
`define PLE_F_CHIPRST_EN 8
`define PLE_F_CP_HI 11
`define PLE_F_CP_LO 9

// ===================================
// Lookup table register
`define PLE_LUT_W 16
`define PLE_LUT_RST 16'h0000
`define PLE_LUT_SUM_HI 7
`define PLE_LUT_SUM_LO 0
`define PLE_LUT_CRY_HI 15
`define PLE_LUT_CRY_LO 8

// ===================================
// Element register and read data reset values
`define PLE_CELL_RST 1'b0
`define PLE_RDATA_RST 32'h00000000

// ===================================
// Status register fields
`define PLE_ST_REG 0
`define PLE_ST_LUT 1
`define PLE_ST_CARRY 2
`define PLE_ST_CASC 3
`define PLE_ST_TRI 4
`define PLE_ST_ASYNC 5

// ===================================
// Operating modes
`define PLE_MODE_NORMAL 2'h0
`define PLE_MODE_ARITH 2'h1
`define PLE_MODE_UPDN 2'h2
`define PLE_MODE_CLRCNT 2'h3

// ===================================
// Clear and preset configurations
`define PLE_CP_CLR 3'h0
`define PLE_CP_PRE 3'h1
`define PLE_CP_CLRPRE 3'h2
`define PLE_CP_LOADCLR 3'h3
`define PLE_CP_LOADPRE 3'h4
`define PLE_CP_LOAD 3'h5

// ===================================
// Emulated internal bus
`define PLE_TRI_N 4

`endif

// ---- logic/ple_cell.v ----
// Programmable logic element with APB configuration registers
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "ple_consts.vh"

module ple_cell (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PLE_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Data inputs from local routing
   input wire firstDataIn,
   input wire secondDataIn,
   input wire thirdDataIn,
   input wire fourthDataIn,
   // Chains from the neighbouring element
   input wire carryIn,
   input wire cascadeIn,
   // Block controls and chip-wide reset
   input wire blockCtrlOne,
   input wire blockCtrlTwo,
   input wire chipReset_n,
   // Emulated internal bus drivers
   input wire [`PLE_TRI_N-1:0] triData,
   input wire [`PLE_TRI_N-1:0] triEnable,
   // Element outputs
   output wire localOut,
   output wire globalOut,
   output wire carryOut,
   output wire cascadeOut,
   output wire triBusOut
);

   // ===================================
   // Helpers
   function lut3Pick;
      input [7:0] table8;
      input [2:0] idx;
      begin
         lut3Pick = table8[idx];
      end
   endfunction

   function [2:0] regSel;
      input [`PLE_ADDR_W-1:0] a;
      begin
         regSel = {a == `PLE_OFF_STATUS, a == `PLE_OFF_LUT, a == `PLE_OFF_CTRL};
      end
   endfunction

   function isMapped;
      input [`PLE_ADDR_W-1:0] a;
      begin
         isMapped = |regSel(a);
      end
   endfunction

   function [31:0] readWord;
      input [2:0] sel;
      input [`PLE_CTRL_W-1:0] ctrlWord;
      input [`PLE_LUT_W-1:0] lutWord;
      input [31:0] statWord;
      begin
         readWord = `PLE_RDATA_RST;
         if (sel[0]) begin
            readWord = {20'h00000, ctrlWord};
         end
         if (sel[1]) begin
            readWord = {16'h0000, lutWord};
         end
         if (sel[2]) begin
            readWord = statWord;
         end
      end
   endfunction

   // ===================================
   // Configuration registers
   reg [`PLE_CTRL_W-1:0] ctrl_q;
   reg [`PLE_LUT_W-1:0] lut_q;
   reg cellReg_q;
   reg cellReg_d;
   wire apbWrite;
   wire apbSetup;

   assign apbWrite = psel & penable & pwrite;
   assign apbSetup = psel & ~penable;
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~isMapped(paddr);

   wire [1:0] mode;
   wire [2:0] cpMode;
   assign mode = ctrl_q[`PLE_F_MODE_HI:`PLE_F_MODE_LO];
   assign cpMode = ctrl_q[`PLE_F_CP_HI:`PLE_F_CP_LO];

   // ===================================
   // Address decode
   wire [2:0] hitSel;
   wire ctrlWe;
   wire lutWe;

   // Offsets decode in one place so write, read and error always agree
   assign hitSel = regSel(paddr);
   assign ctrlWe = apbWrite & hitSel[0];
   assign lutWe = apbWrite & hitSel[1];

   always @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q <= `PLE_CTRL_RST;
         lut_q <= `PLE_LUT_RST;
      end else begin
         if (ctrlWe) begin
            ctrl_q <= pwdata[`PLE_CTRL_W-1:0];
         end
         if (lutWe) begin
            lut_q <= pwdata[`PLE_LUT_W-1:0];
         end
      end
   end

   // ===================================
   // Lookup functions
   wire lutThird;
   wire [2:0] arithIdx;
   wire [2:0] countIdx;
   reg lutOut;
   reg carryOutRaw;
   wire storedInv;
   wire visibleReg;

   assign lutThird = ctrl_q[`PLE_F_LUT_CARRY] ? carryIn : thirdDataIn;
   assign arithIdx = {carryIn, secondDataIn, firstDataIn};
   // Counter feedback: carry, direction or count enable on second input, register bit
   assign countIdx = {carryIn, secondDataIn, visibleReg};

   always @* begin
      lutOut = 1'b0;
      carryOutRaw = 1'b0;
      case (mode)
         `PLE_MODE_NORMAL: begin
            lutOut = lut_q[{fourthDataIn, lutThird, secondDataIn, firstDataIn}];
            carryOutRaw = carryIn;
         end
         `PLE_MODE_ARITH: begin
            lutOut = lut3Pick(lut_q[`PLE_LUT_SUM_HI:`PLE_LUT_SUM_LO], arithIdx);
            carryOutRaw = lut3Pick(lut_q[`PLE_LUT_CRY_HI:`PLE_LUT_CRY_LO], arithIdx);
         end
         `PLE_MODE_UPDN, `PLE_MODE_CLRCNT: begin
            lutOut = lut3Pick(lut_q[`PLE_LUT_SUM_HI:`PLE_LUT_SUM_LO], countIdx);
            carryOutRaw = lut3Pick(lut_q[`PLE_LUT_CRY_HI:`PLE_LUT_CRY_LO], countIdx);
         end
         default: begin
            lutOut = 1'b0;
            carryOutRaw = 1'b0;
         end
      endcase
   end

   assign carryOut = carryOutRaw;
   // Cascade works in normal and arithmetic modes; the clearable counter reuses cascade-in as a control
   assign cascadeOut = (ctrl_q[`PLE_F_CASC_EN] && !mode[1]) ?
      (lutOut & cascadeIn) : lutOut;

   // ===================================
   // Synchronous data path
   reg syncNext;
   wire loadMux;
   wire clockEn;

   // Fourth input selects load, third input carries the load value
   assign loadMux = fourthDataIn ? thirdDataIn : lutOut;
   // Gating stops only the synchronous path; forced values still land
   assign clockEn = ctrl_q[`PLE_F_CE_FIRST_DATA_INPUT] ? firstDataIn : 1'b1;

   always @* begin
      syncNext = 1'b0;
      case (mode)
         `PLE_MODE_NORMAL: begin
            syncNext = ctrl_q[`PLE_F_PACKED] ? fourthDataIn : lutOut;
         end
         `PLE_MODE_ARITH: begin
            syncNext = lutOut;
         end
         `PLE_MODE_UPDN: begin
            syncNext = loadMux;
         end
         `PLE_MODE_CLRCNT: begin
            // Cascade-in is the active-low synchronous clear here
            syncNext = loadMux & cascadeIn;
         end
         default: begin
            syncNext = 1'b0;
         end
      endcase
   end

   // ===================================
   // Asynchronous load terms
   wire loadOne;
   wire loadZero;

   // A load raises preset for a one and clear for a zero, never both
   assign loadOne = blockCtrlOne & thirdDataIn;
   assign loadZero = blockCtrlOne & ~thirdDataIn;

   // ===================================
   // Clear and preset control
   reg clr_n;
   reg pre_n;
   wire chipRstActive;
   wire asyncActive;
   wire asyncValue;

   always @* begin
      clr_n = 1'b1;
      pre_n = 1'b1;
      case (cpMode)
         `PLE_CP_CLR: begin
            clr_n = ~(blockCtrlOne | blockCtrlTwo);
         end
         `PLE_CP_PRE: begin
            // Behaves as a load of a third input tied high
            pre_n = ~blockCtrlOne;
         end
         `PLE_CP_CLRPRE: begin
            pre_n = ~blockCtrlOne;
            clr_n = ~blockCtrlTwo;
         end
         `PLE_CP_LOADCLR: begin
            pre_n = ~loadOne;
            clr_n = ~(loadZero | blockCtrlTwo);
         end
         `PLE_CP_LOADPRE: begin
            // Stored bit is inverted, so the load value is inverted on the way in
            pre_n = ~(loadZero & ~blockCtrlTwo);
            clr_n = ~(loadOne | blockCtrlTwo);
         end
         `PLE_CP_LOAD: begin
            pre_n = ~loadOne;
            clr_n = ~loadZero;
         end
         default: begin
            clr_n = 1'b1;
            pre_n = 1'b1;
         end
      endcase
   end

   assign chipRstActive = ctrl_q[`PLE_F_CHIPRST_EN] & ~chipReset_n;
   // Chip reset clears the stored bit; an inverted register therefore shows one
   assign asyncActive = chipRstActive | ~clr_n | ~pre_n;
   assign asyncValue = (chipRstActive | ~clr_n) ? 1'b0 : 1'b1;

   // ===================================
   // Element register
   // The forced value is shown at once and also captured, so it holds after release
   assign storedInv = (cpMode == `PLE_CP_LOADPRE);

   // ===================================
   // Stored value
   wire syncStored;
   // The stored bit is inverted in load-with-preset, so the sync path follows
   assign syncStored = syncNext ^ storedInv;

   always @* begin
      if (asyncActive) begin
         cellReg_d = asyncValue;
      end else if (clockEn) begin
         cellReg_d = syncStored;
      end else begin
         cellReg_d = cellReg_q;
      end
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         cellReg_q <= `PLE_CELL_RST;
      end else begin
         cellReg_q <= cellReg_d;
      end
   end

   assign visibleReg = (asyncActive ? asyncValue : cellReg_q) ^ storedInv;

   // ===================================
   // Output routing
   wire [1:0] outFromReg;
   wire [1:0] outPick;
   genvar h;

   assign outFromReg = {ctrl_q[`PLE_F_GLOBAL_REG], ctrl_q[`PLE_F_LOCAL_REG]};
   generate
      for (h = 0; h < 2; h = h + 1) begin : outStage
         // The local and global register bits let each output take a different source
         assign outPick[h] = outFromReg[h] ? visibleReg : lutOut;
      end
   endgenerate
   assign localOut = outPick[0];
   assign globalOut = outPick[1];

   // ===================================
   // Emulated internal bus
   wire [`PLE_TRI_N:0] triAny;
   wire [`PLE_TRI_N:0] triMulti;
   wire [`PLE_TRI_N:0] triPick;
   genvar g;

   // Walk the drivers in order; a second enable marks contention
   assign triAny[0] = 1'b0;
   assign triMulti[0] = 1'b0;
   assign triPick[0] = 1'b1;

   generate
      for (g = 0; g < `PLE_TRI_N; g = g + 1) begin : triStage
         assign triAny[g + 1] = triAny[g] | triEnable[g];
         assign triMulti[g + 1] = triMulti[g] | (triAny[g] & triEnable[g]);
         assign triPick[g + 1] = triEnable[g] ? triData[g] : triPick[g];
      end
   endgenerate

   // Contention resolves low, a floating bus high
   assign triBusOut = !triAny[`PLE_TRI_N] ? 1'b1 :
      (triMulti[`PLE_TRI_N] ? 1'b0 : triPick[`PLE_TRI_N]);

   // ===================================
   // Register read
   reg [31:0] statusWord;

   always @* begin
      statusWord = `PLE_RDATA_RST;
      statusWord[`PLE_ST_REG] = visibleReg;
      statusWord[`PLE_ST_LUT] = lutOut;
      statusWord[`PLE_ST_CARRY] = carryOut;
      statusWord[`PLE_ST_CASC] = cascadeOut;
      statusWord[`PLE_ST_TRI] = triBusOut;
      statusWord[`PLE_ST_ASYNC] = asyncActive;
   end

   always @(posedge clock) begin
      if (!rst_n) begin
         prdata <= `PLE_RDATA_RST;
      end else if (apbSetup && !pwrite) begin
         prdata <= readWord(hitSel, ctrl_q, lut_q, statusWord);
      end
   end

endmodule

// ---- tb/ple_cell_checker.sv ----
// Port assertions for the programmable logic element
`include "ple_consts.vh"
module ple_cell_checker (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PLE_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   // Element
   input wire firstDataIn,
   input wire thirdDataIn,
   input wire carryIn,
   input wire cascadeIn,
   input wire blockCtrlOne,
   input wire blockCtrlTwo,
   input wire chipReset_n,
   input wire [`PLE_TRI_N-1:0] triData,
   input wire [`PLE_TRI_N-1:0] triEnable,
   input wire localOut,
   input wire carryOut,
   input wire cascadeOut,
   input wire triBusOut
);
   timeunit 1ns;
   timeprecision 1ps;
   // ===================================
   // Shadow of the control word, since the checker only sees the bus
   logic [11:0] ctrl_q;
   wire ctrlWr = psel && penable && pwrite && pready && paddr == `PLE_OFF_CTRL;
   always @(posedge clock)
      if (!rst_n) ctrl_q <= `PLE_CTRL_RST;
      else if (ctrlWr) ctrl_q <= pwdata[11:0];
   wire [2:0] cp = ctrl_q[11:9];
   wire normOrAr = ctrl_q[1:0] < 2'h2;
   wire quiet = !blockCtrlOne && !blockCtrlTwo && (chipReset_n || !ctrl_q[8]);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ===================================
   // Assertions
   AST_SLVERR: assert property (psel && penable && paddr > `PLE_OFF_STATUS |-> pslverr)
      else $error("unmapped access without error");
   AST_TRI_NONE: assert property (triEnable == 4'h0 |-> triBusOut)
      else $error("idle bus not high");
   AST_TRI_MULTI: assert property (!$onehot0(triEnable) |-> !triBusOut)
      else $error("contended bus not low");
   AST_TRI_ONE: assert property ($onehot(triEnable) |-> triBusOut == |(triData & triEnable))
      else $error("single driver not passed");
   AST_NORM_CARRY: assert property (ctrl_q[1:0] == 2'h0 |-> carryOut == carryIn)
      else $error("normal mode carry not passed");
   AST_CASC: assert property (normOrAr && ctrl_q[3] && !cascadeIn |-> !cascadeOut)
      else $error("cascade not combined");
   AST_CLR: assert property (cp == `PLE_CP_CLR && ctrl_q[5] && !quiet |-> !localOut)
      else $error("clear did not act");
   AST_CHIPRST: assert property (ctrl_q[8] && !chipReset_n && ctrl_q[5] && cp != `PLE_CP_LOADPRE
      |-> !localOut)
      else $error("chip reset did not act");
   AST_LOAD: assert property (cp == `PLE_CP_LOAD && ctrl_q[5] && blockCtrlOne
      && (chipReset_n || !ctrl_q[8]) |-> localOut == thirdDataIn)
      else $error("asynchronous load wrong");
   AST_HOLD: assert property (ctrl_q[7] && !firstDataIn && ctrl_q[5] && quiet && !ctrlWr
      |=> quiet |-> $stable(localOut))
      else $error("register moved while disabled");
   cover property (cp == `PLE_CP_LOAD && blockCtrlOne);
   cover property (!$onehot0(triEnable));
   cover property (ctrl_q[7] && !firstDataIn && quiet);
endmodule
bind ple_cell ple_cell_checker i_chk (.*);

// ---- tb/ple_nbr.sv ----
// Neighbouring element that drives the carry and cascade chains
module ple_nbr (
   // Clock
   input wire clock,
   // Requested chain values and pace
   input wire [1:0] want,
   input wire slow,
   // Chains toward the element
   output wire carry,
   output wire cascade
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] chain_q = 2'h0;
   // A slow neighbour shows its values one cycle late, as a registered element would
   always @(posedge clock) chain_q <= want;
   assign {carry, cascade} = slow ? chain_q : want;
endmodule

// ---- tb/programmable_logic_element_test.sv ----
// Self-checking bench for the programmable logic element
`include "ple_consts.vh"
module programmable_logic_element_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, pe;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic firstDataIn = 0, secondDataIn = 0, thirdDataIn = 0, fourthDataIn = 0;
   logic blockCtrlOne = 0, blockCtrlTwo = 0, chipReset_n = 1, carryIn, cascadeIn;
   logic [3:0] triData = 0, triEnable = 0;
   logic localOut, globalOut, carryOut, cascadeOut, triBusOut, slow = 0, live = 0, sReg;
   logic [1:0] want = 0;
   logic [11:0] ctrlM = 0;
   logic [15:0] lutM = 0;
   logic [5:0] m;
   logic [11:0] cfgs [12] = '{12'h000, 12'h03c, 12'h0b0, 12'h049, 12'h062, 12'h163,
      12'h334, 12'h530, 12'h7b0, 12'h930, 12'hb30, 12'hcb0};
   int n_mismatch = 0, cmp_count = 0, seed = 52;
   always #10 clock = ~clock;
   ple_cell i_dut (.*);
   ple_nbr i_nbr (.clock(clock), .want(want), .slow(slow), .carry(carryIn), .cascade(cascadeIn));
   // ===================================
   // Reference model
   function automatic logic [5:0] mdl(logic [11:0] c, logic [15:0] t, logic s, logic [3:0] dd,
         logic ci, cs, a1, a2, rn, logic [3:0] xd, xe);
      logic [2:0] cp;
      logic vis, act, ov, lo, sy, nx;
      int ix;
      cp = c[11:9];
      vis = (cp == 3'h4) ? ~s : s;
      act = 1;
      ov = 0;
      if (c[8] && !rn) ov = (cp == 3'h4);
      else if (cp == 3'h0 && (a1 || a2)) ov = 0;
      else if ((cp == 3'h2 || cp == 3'h3) && a2) ov = 0;
      else if (cp == 3'h4 && a2) ov = 1;
      else if ((cp == 3'h1 || cp == 3'h2) && a1) ov = 1;
      else if (cp >= 3'h3 && cp <= 3'h5 && a1) ov = dd[2];
      else act = 0;
      if (act) vis = ov;
      ix = c[1:0] == 2'h0 ? {dd[3], c[2] ? ci : dd[2], dd[1], dd[0]} :
         c[1:0] == 2'h1 ? {1'b0, ci, dd[1], dd[0]} : {1'b0, ci, dd[1], vis};
      lo = t[ix];
      sy = c[1:0] == 2'h0 ? (c[4] ? dd[3] : lo) : c[1:0] == 2'h1 ? lo :
         (dd[3] ? dd[2] : lo) & (c[1:0] != 2'h3 || cs);
      nx = act ? ov : (c[7] && !dd[0]) ? vis : sy;
      return {nx ^ (cp == 3'h4), c[5] ? vis : lo, c[6] ? vis : lo,
         c[1:0] == 2'h0 ? ci : t[8 + ix], (c[1:0] < 2'h2 && c[3]) ? lo & cs : lo,
         xe == 4'h0 ? 1'b1 : $onehot(xe) ? |(xd & xe) : 1'b0};
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task results();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Model state follows the same edge as the design
   always @(negedge clock) begin
      m = mdl(ctrlM, lutM, sReg, {fourthDataIn, thirdDataIn, secondDataIn, firstDataIn},
         carryIn, cascadeIn, blockCtrlOne, blockCtrlTwo, chipReset_n, triData, triEnable);
      if (live && rst_n) begin
         chk("localOut", 32'(m[4]), 32'(localOut));
         chk("globalOut", 32'(m[3]), 32'(globalOut));
         chk("carryOut", 32'(m[2]), 32'(carryOut));
         chk("cascadeOut", 32'(m[1]), 32'(cascadeOut));
         chk("triBusOut", 32'(m[0]), 32'(triBusOut));
      end
   end
   always @(posedge clock) sReg <= rst_n ? m[5] : 1'b0;
   // ===================================
   // APB master
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_mismatch++;
         results();
      end
      rd = prdata;
      pe = pslverr;
      if (w && a == `PLE_OFF_CTRL) ctrlM <= wd[11:0];
      if (w && a == `PLE_OFF_LUT) lutM <= wd[15:0];
      psel <= 0;
      penable <= 0;
   endtask
   task run(input logic [11:0] c, input int k);
      apb(1, `PLE_OFF_CTRL, {20'h0, c});
      apb(0, `PLE_OFF_CTRL, 0);
      chk("ctrl", {20'h0, c}, rd);
      apb(1, `PLE_OFF_LUT, $random(seed));
      apb(0, `PLE_OFF_LUT, 0);
      chk("lut", {16'h0, lutM}, rd);
      slow <= k[0];
      repeat (40) begin
         @(posedge clock);
         {fourthDataIn, thirdDataIn, secondDataIn, firstDataIn} <= 4'($random(seed));
         blockCtrlOne <= 3'($random(seed)) == 3'h0;
         blockCtrlTwo <= 3'($random(seed)) == 3'h0 && c[11:9] != `PLE_CP_PRE;
         chipReset_n <= 4'($random(seed)) != 4'h0;
         {triData, triEnable} <= 8'($random(seed));
         want <= 2'($random(seed));
      end
      @(posedge clock);
      blockCtrlOne <= 0;
      blockCtrlTwo <= 0;
      chipReset_n <= 1;
      $display("test %0d done", k);
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1;
      live <= 1;
      apb(0, `PLE_OFF_CTRL, 0);
      chk("ctrl reset", 32'h0, rd);
      apb(0, 8'h0c, 0);
      chk("unmapped read", 32'h0, rd);
      chk("unmapped error", 32'h1, 32'(pe));
      foreach (cfgs[k]) run(cfgs[k], k);
      results();
   end
endmodule
